// ==== bench/rfs_properties.sv ====
// assertion checker for the fault status bank
`timescale 1ns/1ps
module rfs_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [rfs_pkg::ADDR_W-1:0] regAddr,
   input wire logic regRd,
   input wire logic [rfs_pkg::DATA_W-1:0] regRdata,
   input wire logic [rfs_pkg::NUM_REC-1:0] recFaultValid,
   input wire logic recOverflow,
   input wire logic invTimeout,
   input wire logic invCompletionErr,
   input wire logic invQueueErr,
   input wire logic advLogFirstWrite,
   input wire logic advLogOverflow,
   input wire logic recordEnable
);
   import rfs_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence rdStat;
      regRd && regAddr == FAULT_STATUS_OFS;
   endsequence
   // an event must show in a status read issued the next cycle
   property pSet(ev, int b);
      ev ##1 rdStat |=> regRdata[b];
   endproperty
   a_tmo_flag_sets: assert property (pSet(invTimeout, INV_TO_BIT))
      else $error("timeout flag missing");
   a_cpl_flag_sets: assert property (
      pSet(invCompletionErr, INV_CPL_BIT))
      else $error("completion flag missing");
   a_queue_flag_sets: assert property (pSet(invQueueErr, INV_Q_BIT))
      else $error("queue flag missing");
   a_adv_pend_sets: assert property (
      pSet(advLogFirstWrite, ADV_PEND_BIT))
      else $error("advanced pending flag missing");
   a_adv_ovf_sets: assert property (pSet(advLogOverflow, ADV_OVF_BIT))
      else $error("advanced overflow flag missing");
   a_rec_ovf_sets: assert property (pSet(recOverflow, REC_OVF_BIT))
      else $error("record overflow flag missing");
   a_ovf_stops_rec: assert property (recOverflow |=> !recordEnable)
      else $error("recording still enabled");
   a_pend_is_or: assert property (rdStat ##0 $stable(recFaultValid) |=>
      regRdata[PRI_PEND_BIT] == |$past(recFaultValid))
      else $error("pending flag differs from record OR");
   a_reserved_zero: assert property (rdStat |=>
      regRdata[31:16] == 16'h0000 && !regRdata[7])
      else $error("reserved bits not zero");
endmodule

bind remap_fault_status rfs_checker u_rfs_checker (.clk, .rst_n, .regAddr,
   .regRd, .regRdata, .recFaultValid, .recOverflow, .invTimeout,
   .invCompletionErr, .invQueueErr, .advLogFirstWrite, .advLogOverflow,
   .recordEnable);

// ==== bench/tb_remap_fault_status.sv ====
// self-checking bench for the fault status bank
`timescale 1ns/1ps
module tb_remap_fault_status;
   import rfs_pkg::*;
   logic clk = 0, rst_n = 0, regWr = 0, regRd = 0, recOverflow = 0;
   logic invTimeout = 0, invCompletionErr = 0, invQueueErr = 0;
   logic advLogFirstWrite = 0, advLogOverflow = 0;
   logic recordEnable, faultEvent, irq;
   logic [ADDR_W-1:0] regAddr = '0;
   logic [DATA_W-1:0] regWdata = '0, regRdata, rdQ, w, m;
   logic [NUM_REC-1:0] recFaultValid = '0, v;
   logic [6:0] stat = '0, ev;
   logic [7:0] idx = '0;
   int seed = 14, nErrors = 0, nTests = 0, cyc = 0, k;
   always #25 clk = ~clk;
   remap_fault_status u_remap_fault_status (.clk, .rst_n, .regAddr,
      .regWdata, .regWr, .regRd, .regRdata, .recFaultValid, .recOverflow,
      .invTimeout, .invCompletionErr, .invQueueErr, .advLogFirstWrite,
      .advLogOverflow, .recordEnable, .faultEvent, .irq);
   task automatic give_verdict();
      $display("tests %0d errors %0d", nTests, nErrors);
      if (nErrors == 0 && nTests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         nErrors++;
         give_verdict();
      end
   end
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         nErrors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(logic [ADDR_W-1:0] a);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rdQ = regRdata;
   endtask
   // a status read right behind the event edge exercises the flag checks
   task automatic pulse(logic [6:0] e, bit rdBack);
      @(posedge clk);
      {invTimeout, invCompletionErr, invQueueErr, advLogFirstWrite,
         advLogOverflow, recOverflow} <= {e[6:2], e[0]};
      @(posedge clk);
      {invTimeout, invCompletionErr, invQueueErr, advLogFirstWrite,
         advLogOverflow, recOverflow} <= 6'h00;
      if (rdBack) begin
         regRd <= 1'b1;
         regAddr <= FAULT_STATUS_OFS;
         @(posedge clk);
         regRd <= 1'b0;
      end
   endtask
   // the event output is a single-cycle pulse, so poll it each cycle
   task automatic evWait();
      k = 0;
      #1;
      while (faultEvent !== 1'b1 && k < 4) begin
         @(posedge clk);
         #1 k++;
      end
   endtask
   function automatic logic [7:0] first(logic [7:0] x);
      first = 8'h00;
      for (int j = 7; j >= 0; j--)
         if (x[j]) first = 8'(j);
   endfunction
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(FAULT_STATUS_OFS);
      check("reset status", rdQ, 32'h0);
      rd(EVT_MASK_OFS);
      check("reset mask", rdQ, 32'h7F);
      rd(12'h3FC);
      check("unmapped read", rdQ, 32'h0);
      for (int i = 0; i < 40; i++) begin
         ev = (i < 7) ? 7'h01 << i : 7'($random(seed));
         pulse(ev & 7'h7D, 1'b1);
         stat |= ev & 7'h7D;
         v = (i % 3 == 0) ? 8'h00 : 8'($random(seed));
         if (!(|recFaultValid) && |v) idx = first(v);
         recFaultValid <= v;
         w = (i < 7) ? 32'h0 : $random(seed);
         wr(FAULT_STATUS_OFS, w);
         stat &= ~w[6:0];
         rd(FAULT_STATUS_OFS);
         // record index keeps its last captured value while nothing is pending
         m = (|v) ? 32'hFFFFFFFF : 32'hFFFF00FF;
         check("status", rdQ & m,
            {16'h0, idx, 1'b0, stat[6:2], |v, stat[0]} & m);
         check("record enable", 32'(recordEnable), 32'(!stat[0]));
      end
      wr(EVT_STATUS_OFS, 32'h7F);
      wr(EVT_MASK_OFS, 32'h0);
      pulse(7'h10, 1'b0);
      evWait();
      check("queue event", 32'(faultEvent), 32'h1);
      rd(EVT_STATUS_OFS);
      check("event status", rdQ, 32'h10);
      check("irq set", 32'(irq), 32'h1);
      wr(EVT_STATUS_OFS, 32'h7F);
      recFaultValid <= 8'h00;
      rd(FAULT_STATUS_OFS);
      check("irq clear", 32'(irq), 32'h0);
      @(posedge clk);
      recFaultValid <= 8'h60;
      evWait();
      check("pending event", 32'(faultEvent), 32'h1);
      rd(FAULT_STATUS_OFS);
      check("first index", 32'(rdQ[15:8]), 32'h5);
      give_verdict();
   end
endmodule

// ==== rtl/remap_fault_status.sv ====
// fault status register bank of the address-remapping unit
`timescale 1ns/1ps
module remap_fault_status #(
   parameter bit HAS_DEV_CACHE = 1'b1,
   parameter bit HAS_QUEUED_INV = 1'b1,
   parameter bit HAS_ADV_LOG = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [rfs_pkg::ADDR_W-1:0] regAddr,
   input wire logic [rfs_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [rfs_pkg::DATA_W-1:0] regRdata,
   input wire logic [rfs_pkg::NUM_REC-1:0] recFaultValid,
   input wire logic recOverflow,
   input wire logic invTimeout,
   input wire logic invCompletionErr,
   input wire logic invQueueErr,
   input wire logic advLogFirstWrite,
   input wire logic advLogOverflow,
   output logic recordEnable,
   output logic faultEvent,
   output logic irq
);
   import rfs_pkg::*;

   logic wrStatus;
   logic wrEvt;
   logic wrMask;
   logic [IDX_W-1:0] firstIdx;
   logic priPendD;
   logic priPendQ;
   logic priRise;
   logic invToQ;
   logic invCplQ;
   logic invQQ;
   logic advPendQ;
   logic advOvfQ;
   logic recOvfQ;
   logic [IDX_W-1:0] recIdxQ;
   logic [NUM_EVT-1:0] evtSet;
   logic [NUM_EVT-1:0] evtQ;
   logic [NUM_EVT-1:0] maskQ;
   logic [DATA_W-1:0] statusWord;
   logic [DATA_W-1:0] rdD;

   assign wrStatus = regWr && (regAddr == FAULT_STATUS_OFS);
   assign wrEvt = regWr && (regAddr == EVT_STATUS_OFS);
   assign wrMask = regWr && (regAddr == EVT_MASK_OFS);

   // lowest-numbered valid record is taken as the first pending one
   always_comb begin
      firstIdx = '0;
      for (int i = NUM_REC - 1; i >= 0; i--) begin
         if (recFaultValid[i]) begin
            firstIdx = IDX_W'(i);
         end
      end
   end

   assign priPendD = |recFaultValid;
   assign priRise = priPendD && !priPendQ;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         priPendQ <= 1'b0;
      end else begin
         priPendQ <= priPendD;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         recIdxQ <= '0;
      end else if (priRise) begin
         recIdxQ <= firstIdx;
      end
   end

   rfs_sticky_bit #(.PRESENT(HAS_DEV_CACHE)) uInvTo (
      .clk(clk),
      .rst_n(rst_n),
      .setIn(invTimeout),
      .clrIn(wrStatus && regWdata[INV_TO_BIT]),
      .flagQ(invToQ)
   );
   rfs_sticky_bit #(.PRESENT(HAS_DEV_CACHE)) uInvCpl (
      .clk(clk),
      .rst_n(rst_n),
      .setIn(invCompletionErr),
      .clrIn(wrStatus && regWdata[INV_CPL_BIT]),
      .flagQ(invCplQ)
   );
   rfs_sticky_bit #(.PRESENT(HAS_QUEUED_INV)) uInvQ (
      .clk(clk),
      .rst_n(rst_n),
      .setIn(invQueueErr),
      .clrIn(wrStatus && regWdata[INV_Q_BIT]),
      .flagQ(invQQ)
   );
   rfs_sticky_bit #(.PRESENT(HAS_ADV_LOG)) uAdvPend (
      .clk(clk),
      .rst_n(rst_n),
      .setIn(advLogFirstWrite),
      .clrIn(wrStatus && regWdata[ADV_PEND_BIT]),
      .flagQ(advPendQ)
   );
   rfs_sticky_bit #(.PRESENT(HAS_ADV_LOG)) uAdvOvf (
      .clk(clk),
      .rst_n(rst_n),
      .setIn(advLogOverflow),
      .clrIn(wrStatus && regWdata[ADV_OVF_BIT]),
      .flagQ(advOvfQ)
   );
   rfs_sticky_bit #(.PRESENT(1'b1)) uRecOvf (
      .clk(clk),
      .rst_n(rst_n),
      .setIn(recOverflow),
      .clrIn(wrStatus && regWdata[REC_OVF_BIT]),
      .flagQ(recOvfQ)
   );

   // recording stops while the overflow flag stands
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         recordEnable <= 1'b1;
      end else begin
         recordEnable <= !(recOvfQ || recOverflow);
      end
   end

   // event sources, only counted when the feature exists
   always_comb begin
      evtSet = '0;
      evtSet[INV_TO_BIT] = invTimeout && HAS_DEV_CACHE;
      evtSet[INV_CPL_BIT] = invCompletionErr && HAS_DEV_CACHE;
      evtSet[INV_Q_BIT] = invQueueErr && HAS_QUEUED_INV;
      // first-record event only while the pending flag was clear
      evtSet[ADV_PEND_BIT] = advLogFirstWrite && !advPendQ && HAS_ADV_LOG;
      evtSet[ADV_OVF_BIT] = advLogOverflow && HAS_ADV_LOG;
      evtSet[PRI_PEND_BIT] = priRise;
      evtSet[REC_OVF_BIT] = recOverflow;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         faultEvent <= 1'b0;
      end else begin
         faultEvent <= |(evtSet & ~maskQ);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         evtQ <= EVT_RESET;
      end else begin
         // set wins over a same-cycle clear
         evtQ <= (evtQ & ~({NUM_EVT{wrEvt}} & regWdata[NUM_EVT-1:0]))
            | evtSet;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         maskQ <= MASK_RESET;
      end else if (wrMask) begin
         maskQ <= regWdata[NUM_EVT-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(evtQ & ~maskQ);
      end
   end

   always_comb begin
      statusWord = '0;
      statusWord[IDX_LSB +: IDX_W] = recIdxQ;
      statusWord[INV_TO_BIT] = invToQ;
      statusWord[INV_CPL_BIT] = invCplQ;
      statusWord[INV_Q_BIT] = invQQ;
      statusWord[ADV_PEND_BIT] = advPendQ;
      statusWord[ADV_OVF_BIT] = advOvfQ;
      statusWord[PRI_PEND_BIT] = priPendQ;
      statusWord[REC_OVF_BIT] = recOvfQ;
   end

   always_comb begin
      rdD = '0;
      unique case (regAddr)
         FAULT_STATUS_OFS: rdD = statusWord;
         EVT_STATUS_OFS: rdD[NUM_EVT-1:0] = evtQ;
         EVT_MASK_OFS: rdD[NUM_EVT-1:0] = maskQ;
         default: rdD = '0;
      endcase
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regRdata <= '0;
      end else if (regRd) begin
         regRdata <= rdD;
      end else begin
         regRdata <= '0;
      end
   end
endmodule

// ==== rtl/rfs_pkg.sv ====
// constants and register layout of the remap fault status block
package rfs_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int NUM_REC = 8;
   localparam int IDX_W = 8;
   localparam logic [ADDR_W-1:0] FAULT_STATUS_OFS = 12'h034;
   localparam logic [ADDR_W-1:0] EVT_STATUS_OFS = 12'h040;
   localparam logic [ADDR_W-1:0] EVT_MASK_OFS = 12'h044;
   localparam int IDX_LSB = 8;
   localparam int INV_TO_BIT = 6;
   localparam int INV_CPL_BIT = 5;
   localparam int INV_Q_BIT = 4;
   localparam int ADV_PEND_BIT = 3;
   localparam int ADV_OVF_BIT = 2;
   localparam int PRI_PEND_BIT = 1;
   localparam int REC_OVF_BIT = 0;
   localparam int NUM_EVT = 7;
   localparam logic [NUM_EVT-1:0] EVT_RESET = 7'h00;
   localparam logic [NUM_EVT-1:0] MASK_RESET = 7'h7F;
endpackage

// ==== rtl/rfs_sticky_bit.sv ====
// one sticky flag: hardware set beats write-one clear
`timescale 1ns/1ps
module rfs_sticky_bit #(
   parameter bit PRESENT = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic setIn,
   input wire logic clrIn,
   output logic flagQ
);
   always_ff @(posedge clk) begin
      if (!rst_n || !PRESENT) begin
         flagQ <= 1'b0;
      end else if (setIn) begin
         flagQ <= 1'b1;
      end else if (clrIn) begin
         flagQ <= 1'b0;
      end
   end
endmodule
